// >>> test/pulse_counter_model.sv
// ============================================================
// pulse counter at the far side, as a meter register or timer
// assumes pulse outputs are synchronous to aclk in simulation
`timescale 1ns/1ps
module pulse_counter_model (
   input  wire logic aclk,
   input  wire logic energy_pulse_a,
   input  wire logic energy_pulse_b,
   input  wire logic calibration_pulse_out,
   output int        cal_count,
   output int        slow_count,
   output int        last_gap,
   output int        alt_errors
);
   logic a_d, b_d, c_d, was_a;
   int   mark;
   initial begin
      {a_d, b_d, c_d, was_a} = 4'h0;
      {cal_count, slow_count, last_gap, alt_errors, mark} = '0;
   end
   // whole pulses only; the gap is judged between slow pulses, never per window
   always @(posedge aclk) begin
      a_d <= energy_pulse_a;
      b_d <= energy_pulse_b;
      c_d <= calibration_pulse_out;
      if (calibration_pulse_out && !c_d)
         cal_count <= cal_count + 1;
      if ((energy_pulse_a && !a_d) || (energy_pulse_b && !b_d)) begin
         slow_count <= slow_count + 1;
         last_gap   <= cal_count - mark;
         mark       <= cal_count;
         was_a      <= energy_pulse_a && !a_d;
         if (slow_count > 0 && (energy_pulse_a && !a_d) == was_a)
            alt_errors <= alt_errors + 1;
      end
   end
endmodule

// >>> test/tb_polyphase_power_to_pulse_converter.sv
// ============================================================
// bench for the pulse converter: register tasks and sample feeds
// assumes the design with a short slow pulse and the counter model
`timescale 1ns/1ps
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin miscompares++; \
   $display("CHECK FAILED %s expected %0h seen %0h", n, e, s); end end
module tb_polyphase_power_to_pulse_converter;
   logic        aclk = 1'b0, aresetn = 1'b0, supply = 1'b0, sample_valid = 1'b0;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [31:0] wdata = 32'h0, rdata, rd;
   logic [3:0]  wstrb = 4'h0;
   logic        awready, wready, bvalid, arready, rvalid, pa, pb, cf, rev;
   logic [1:0]  bresp, rresp, rs;
   logic [47:0] volt = 48'h0, curr = 48'h0;
   int          cal_count, slow_count, last_gap, alt_errors, c0, s0;
   int          miscompares = 0, checked = 0, cyc = 0;
   always #4 aclk = ~aclk;
   polyphase_power_to_pulse_converter #(.SLOW_PULSE_CYC(20)) uut (
      .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .sample_valid(sample_valid), .volt_samples(volt), .curr_samples(curr),
      .supply_above_trigger(supply), .energy_pulse_a(pa), .energy_pulse_b(pb),
      .calibration_pulse_out(cf), .reverse_power_flag(rev));
   pulse_counter_model far (
      .aclk(aclk), .energy_pulse_a(pa), .energy_pulse_b(pb), .calibration_pulse_out(cf),
      .cal_count(cal_count), .slow_count(slow_count), .last_gap(last_gap),
      .alt_errors(alt_errors));
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 100000) begin
         miscompares++;
         print_verdict();
      end
   end
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      wstrb <= 4'hF;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      forever begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid) break;
      end
      bready <= 1'b0;
      `CHK("bresp", er, bresp)
   endtask
   task automatic rd_reg(input logic [7:0] a);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      forever begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
         if (rvalid) break;
      end
      rready <= 1'b0;
      rd = rdata;
      rs = rresp;
   endtask
   // samples flip sign each set so the offset filters pass them whole
   task automatic feed(input int n, input int sp, input logic [2:0] neg);
      logic [15:0] v;
      for (int k = 0; k < n; k++) begin
         v = k[0] ? 16'hC000 : 16'h4000;
         volt <= {3{v}};
         curr <= {neg[2] ? -v : v, neg[1] ? -v : v, neg[0] ? -v : v};
         sample_valid <= 1'b1;
         @(posedge aclk);
         sample_valid <= 1'b0;
         repeat (sp - 1) @(posedge aclk);
      end
   endtask
   initial begin
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      rd_reg(meter_pkg::ADDR_CTRL);
      `CHK("ctrl reset", 32'(meter_pkg::CTRL_RESET), rd)
      rd_reg(meter_pkg::ADDR_STATUS);
      `CHK("supply at reset", 1'b0, rd[0])
      rd_reg(8'h0C);
      `CHK("unmapped resp", meter_pkg::RESP_SLVERR, rs)
      `CHK("unmapped data", 32'h0, rd)
      wr(8'h0C, 32'h5, meter_pkg::RESP_SLVERR);
      rd_reg(meter_pkg::ADDR_CTRL);
      `CHK("unmapped write", 32'(meter_pkg::CTRL_RESET), rd)
      for (int k = 0; k < 8; k++) begin
         wr(meter_pkg::ADDR_CTRL, 32'(k + 8));
         rd_reg(meter_pkg::ADDR_CTRL);
         `CHK("ctrl select", 32'(k + 8), rd)
      end
      wr(meter_pkg::ADDR_CTRL, 32'hB);
      feed(20, 130, 3'h0);
      `CHK("pulses before supply", 0, cal_count)
      $display("test registers and startup done");
      supply <= 1'b1;
      repeat (1300) @(posedge aclk);
      supply <= 1'b0;
      repeat (40) @(posedge aclk);
      supply <= 1'b1;
      rd_reg(meter_pkg::ADDR_STATUS);
      `CHK("supply after dip", 1'b1, rd[0])
      // a gap over the pulse width keeps every calibration quantum a separate rise
      feed(400, 130, 3'h0);
      `CHK("two slow pulses", 1'b1, slow_count >= 2)
      `CHK("cal per slow", 160, last_gap)
      `CHK("alternation", 0, alt_errors)
      `CHK("forward flag", 1'b0, rev)
      rd_reg(meter_pkg::ADDR_PULSES);
      `CHK("pulse count", 32'(slow_count), rd)
      $display("test pulse ratio done");
      feed(600, 4, 3'h1);
      `CHK("signed one negative", 1'b0, rev)
      rd_reg(meter_pkg::ADDR_STATUS);
      `CHK("phase negative", 3'h1, rd[4:2])
      feed(600, 4, 3'h7);
      `CHK("signed all negative", 1'b1, rev)
      wr(meter_pkg::ADDR_CTRL, 32'h3);
      feed(600, 4, 3'h1);
      repeat (200) @(posedge aclk);
      c0 = cal_count;
      feed(10, 130, 3'h1);
      `CHK("magnitude reverse", 1'b1, rev)
      `CHK("magnitude pulses", 10, cal_count - c0)
      $display("test sum modes done");
      supply <= 1'b0;
      repeat (1300) @(posedge aclk);
      c0 = cal_count;
      s0 = slow_count;
      feed(20, 130, 3'h1);
      `CHK("cal gated", c0, cal_count)
      `CHK("slow gated", s0, slow_count)
      `CHK("reverse gated", 1'b0, rev)
      $display("test supply loss done");
      print_verdict();
   end
endmodule

// >>> verilog/meter_pkg.sv
// ============================================================
// constants shared by the pulse converter and its submodules
// assumes a 125 MHz aclk and sample strobes near 12868 per second
package meter_pkg;
   localparam int CLK_PERIOD_NS = 8;
   localparam int SAMPLE_W      = 16;
   localparam int DC_W          = 27;
   localparam int HP_W          = 17;
   localparam int PWR_W         = 34;
   localparam int LPACC_W       = 42;
   localparam int TOT_W         = 36;
   localparam int ACC_W         = 40;
   localparam int HPF_SHIFT     = 10;
   // one pole, fs / (2*pi*2^8) gives the 8 Hz corner at 12868 samples/s
   localparam int LPF_SHIFT     = 8;

   localparam logic [7:0] CF_TO_SLOW = 8'hA0;
   localparam int CF_PULSE_NS        = 1000;
   localparam logic [7:0] CF_PULSE_CYC =
      8'((CF_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam int SLOW_PULSE_MS  = 10;
   localparam int SLOW_PULSE_CYC = SLOW_PULSE_MS * 1000000 / CLK_PERIOD_NS;
   localparam int SUPPLY_FILTER_US = 10;
   localparam logic [10:0] SUPPLY_FILT_CYC =
      11'(SUPPLY_FILTER_US * 1000 / CLK_PERIOD_NS);

   localparam logic [ACC_W-1:0] DFC_SCALE = 40'h01_0000_0000;

   localparam logic [7:0] ADDR_CTRL   = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_PULSES = 8'h08;
   localparam logic [3:0] CTRL_RESET  = 4'h8;
   localparam int CTRL_LOW   = 0;
   localparam int CTRL_HIGH  = 1;
   localparam int CTRL_SCALE = 2;
   localparam int CTRL_SUM   = 3;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // sel = {scale, high, low}; rate in hundredths of a hertz
   function automatic logic [ACC_W-1:0] rate_threshold(input logic [2:0] sel);
      logic [15:0] centi_hz;
      case (sel)
         3'h0:    centi_hz = 16'h007F;
         3'h4:    centi_hz = 16'h0077;
         3'h1:    centi_hz = 16'h01FD;
         3'h5:    centi_hz = 16'h01DD;
         3'h2:    centi_hz = 16'h0773;
         3'h6:    centi_hz = 16'h0773;
         3'h3:    centi_hz = 16'h1DCD;
         default: centi_hz = 16'h003C;
      endcase
      return DFC_SCALE / ACC_W'(centi_hz);
   endfunction

   function automatic logic [TOT_W-1:0] magnitude(input logic signed [TOT_W-1:0] x);
      return (x < 0) ? TOT_W'(-x) : TOT_W'(x);
   endfunction
endpackage

// >>> verilog/phase_channel.sv
// ============================================================
// one phase: offset removal, multiply, low-pass to real power
// assumes valid pulses one cycle per sample pair
`timescale 1ns/1ps
module phase_channel (
   input wire logic aclk,
   input wire logic aresetn,
   phase_if.calc    ch
);
   typedef struct packed {
      logic signed [meter_pkg::DC_W-1:0]    dc_v;
      logic signed [meter_pkg::DC_W-1:0]    dc_i;
      logic signed [meter_pkg::LPACC_W-1:0] lp;
      logic signed [meter_pkg::PWR_W-1:0]   power;
   } chan_state_t;

   chan_state_t st_r;
   chan_state_t st_nxt;
   logic signed [meter_pkg::HP_W-1:0]  hp_v;
   logic signed [meter_pkg::HP_W-1:0]  hp_i;
   logic signed [meter_pkg::PWR_W-1:0] prod;

   function automatic logic signed [meter_pkg::HP_W-1:0] hp_out(
      input logic signed [meter_pkg::DC_W-1:0]     dc,
      input logic signed [meter_pkg::SAMPLE_W-1:0] x);
      return meter_pkg::HP_W'(x) - meter_pkg::HP_W'(dc >>> meter_pkg::HPF_SHIFT);
   endfunction

   function automatic logic signed [meter_pkg::DC_W-1:0] dc_next(
      input logic signed [meter_pkg::DC_W-1:0]     dc,
      input logic signed [meter_pkg::SAMPLE_W-1:0] x);
      return dc + meter_pkg::DC_W'(x) - (dc >>> meter_pkg::HPF_SHIFT);
   endfunction

   // ============================================================
   // datapath
   always_comb begin
      st_nxt = st_r;
      hp_i   = hp_out(st_r.dc_i, ch.curr);
      // same filter on the voltage path keeps both phase shifts equal
      hp_v   = hp_out(st_r.dc_v, ch.volt);
      prod   = hp_v * hp_i;
      if (ch.valid) begin
         st_nxt.dc_i  = dc_next(st_r.dc_i, ch.curr);
         st_nxt.dc_v  = dc_next(st_r.dc_v, ch.volt);
         st_nxt.lp    = st_r.lp + meter_pkg::LPACC_W'(prod)
                        - (st_r.lp >>> meter_pkg::LPF_SHIFT);
         st_nxt.power = meter_pkg::PWR_W'(st_r.lp >>> meter_pkg::LPF_SHIFT);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign ch.power = st_r.power;

   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_power_hold_idle: assert property (!$past(ch.valid) |-> $stable(ch.power))
      else $error("phase power moved without a sample");
endmodule

// >>> verilog/phase_if.sv
// ============================================================
// samples into one phase channel and its filtered power back out
// assumes one driver per modport side
`timescale 1ns/1ps
interface phase_if;
   logic                                valid;
   logic signed [meter_pkg::SAMPLE_W-1:0] volt;
   logic signed [meter_pkg::SAMPLE_W-1:0] curr;
   logic signed [meter_pkg::PWR_W-1:0]    power;
   modport feed (output valid, volt, curr, input power);
   modport calc (input valid, volt, curr, output power);
endinterface

// >>> verilog/polyphase_power_to_pulse_converter.sv
// ============================================================
// three-phase power to pulse converter with an AXI4-Lite control port
// assumes synchronous sample strobes and one AXI4-Lite master on aclk
//
// The AXI4-Lite interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/1ps

module polyphase_power_to_pulse_converter #(
   parameter int SLOW_PULSE_CYC = meter_pkg::SLOW_PULSE_CYC
) (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [7:0]  awaddr,
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   input  wire logic        wvalid,
   output logic             wready,
   output logic [1:0]       bresp,
   output logic             bvalid,
   input  wire logic        bready,
   input  wire logic [7:0]  araddr,
   input  wire logic        arvalid,
   output logic             arready,
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   output logic             rvalid,
   input  wire logic        rready,
   input  wire logic        sample_valid,
   input  wire logic [47:0] volt_samples,
   input  wire logic [47:0] curr_samples,
   input  wire logic        supply_above_trigger,
   output logic             energy_pulse_a,
   output logic             energy_pulse_b,
   output logic             calibration_pulse_out,
   output logic             reverse_power_flag
);
   typedef struct packed {
      logic [3:0]                    ctrl;
      logic                          aw_got;
      logic                          w_got;
      logic [7:0]                    waddr;
      logic [3:0]                    wbits;
      logic                          wlane0;
      logic                          awready;
      logic                          wready;
      logic                          bvalid;
      logic [1:0]                    bresp;
      logic                          arready;
      logic                          rvalid;
      logic [1:0]                    rresp;
      logic [31:0]                   rdata;
      logic                          valid_d;
      logic [meter_pkg::ACC_W-1:0]   cf_acc;
      logic [7:0]                    slow_div;
      logic [7:0]                    cf_timer;
      logic [31:0]                   slow_timer;
      logic                          slow_on_b;
      logic                          cf_out;
      logic                          pulse_a;
      logic                          pulse_b;
      logic                          rev;
      logic [2:0]                    phase_neg;
      logic [31:0]                   pulse_count;
   } top_state_t;

   top_state_t st_r;
   top_state_t st_nxt;
   logic                                supply_ok;
   logic signed [meter_pkg::PWR_W-1:0]  pw [3];
   logic signed [meter_pkg::TOT_W-1:0]  ext [3];
   logic signed [meter_pkg::TOT_W-1:0]  total_signed;
   logic [meter_pkg::TOT_W-1:0]         addend;
   logic [meter_pkg::ACC_W-1:0]         acc_sum;
   logic [meter_pkg::ACC_W-1:0]         thr;
   logic [2:0]                          neg_now;
   logic                                rev_now;
   logic                                cf_hit;
   logic                                slow_hit;
   logic                                sum_mode_select_n;
   logic                                rate_select_low;
   logic                                rate_select_high;
   logic                                rate_scale_select;

   // ============================================================
   // phase channels and supply filter
   phase_if ph [3] ();

   for (genvar g = 0; g < 3; g++) begin : g_phase
      assign ph[g].valid = sample_valid;
      assign ph[g].volt  = volt_samples[g*16 +: 16];
      assign ph[g].curr  = curr_samples[g*16 +: 16];
      assign pw[g]       = ph[g].power;
      assign ext[g]      = meter_pkg::TOT_W'(pw[g]);
      assign neg_now[g]  = pw[g] < 0;
      phase_channel u_chan (
         .aclk    (aclk),
         .aresetn (aresetn),
         .ch      (ph[g])
      );
   end

   supply_monitor u_supply (
      .aclk                 (aclk),
      .aresetn              (aresetn),
      .supply_above_trigger (supply_above_trigger),
      .supply_ok            (supply_ok)
   );

   assign sum_mode_select_n = st_r.ctrl[meter_pkg::CTRL_SUM];
   assign rate_select_low   = st_r.ctrl[meter_pkg::CTRL_LOW];
   assign rate_select_high  = st_r.ctrl[meter_pkg::CTRL_HIGH];
   assign rate_scale_select = st_r.ctrl[meter_pkg::CTRL_SCALE];

   // ============================================================
   // energy summation and digital-to-frequency conversion
   always_comb begin
      total_signed = ext[0] + ext[1] + ext[2];
      if (sum_mode_select_n) begin
         addend  = meter_pkg::magnitude(total_signed);
         rev_now = total_signed < 0;
      end else begin
         addend  = meter_pkg::magnitude(ext[0]) + meter_pkg::magnitude(ext[1])
                   + meter_pkg::magnitude(ext[2]);
         rev_now = |neg_now;
      end
      thr = meter_pkg::rate_threshold(
               {rate_scale_select, rate_select_high, rate_select_low});
      acc_sum  = st_r.cf_acc + meter_pkg::ACC_W'(addend);
      cf_hit   = supply_ok && st_r.valid_d && acc_sum >= thr;
      slow_hit = cf_hit && st_r.slow_div == meter_pkg::CF_TO_SLOW - 8'h01;
   end

   always_comb begin
      st_nxt         = st_r;
      st_nxt.valid_d = sample_valid;
      // ---- write channel: address and data in either order
      if (st_r.bvalid && bready) begin
         st_nxt.bvalid = 1'b0;
      end
      if (st_r.awready && awvalid) begin
         st_nxt.aw_got = 1'b1;
         st_nxt.waddr  = awaddr;
      end
      if (st_r.wready && wvalid) begin
         st_nxt.w_got  = 1'b1;
         st_nxt.wbits  = wdata[3:0];
         st_nxt.wlane0 = wstrb[0];
      end
      if (st_nxt.aw_got && st_nxt.w_got) begin
         st_nxt.aw_got = 1'b0;
         st_nxt.w_got  = 1'b0;
         st_nxt.bvalid = 1'b1;
         st_nxt.bresp  = meter_pkg::RESP_OKAY;
         if (st_nxt.waddr == meter_pkg::ADDR_CTRL) begin
            if (st_nxt.wlane0) begin
               st_nxt.ctrl = st_nxt.wbits;
            end
         end else if (st_nxt.waddr != meter_pkg::ADDR_STATUS
                      && st_nxt.waddr != meter_pkg::ADDR_PULSES) begin
            st_nxt.bresp = meter_pkg::RESP_SLVERR;
         end
      end
      st_nxt.awready = !st_nxt.aw_got && !st_nxt.bvalid;
      st_nxt.wready  = !st_nxt.w_got && !st_nxt.bvalid;
      // ---- read channel
      if (st_r.rvalid && rready) begin
         st_nxt.rvalid = 1'b0;
      end
      if (st_r.arready && arvalid) begin
         st_nxt.rvalid = 1'b1;
         st_nxt.rresp  = meter_pkg::RESP_OKAY;
         case (araddr)
            meter_pkg::ADDR_CTRL:   st_nxt.rdata = {28'h0000000, st_r.ctrl};
            meter_pkg::ADDR_STATUS: st_nxt.rdata = {27'h0000000, st_r.phase_neg,
                                                    st_r.rev, supply_ok};
            meter_pkg::ADDR_PULSES: st_nxt.rdata = st_r.pulse_count;
            default: begin
               st_nxt.rdata = 32'h00000000;
               st_nxt.rresp = meter_pkg::RESP_SLVERR;
            end
         endcase
      end
      st_nxt.arready = !st_nxt.rvalid;
      // ---- accumulation and pulse shaping
      if (st_r.valid_d) begin
         st_nxt.cf_acc    = cf_hit ? acc_sum - thr : acc_sum;
         // drop a residue of a whole threshold or more: under overload it would grow
         // without bound and wrap the accumulator into a missed quantum
         if (cf_hit && st_nxt.cf_acc >= thr) begin
            st_nxt.cf_acc = '0;
         end
         st_nxt.rev       = rev_now;
         st_nxt.phase_neg = neg_now;
      end
      // one quantum per sample at most; a larger step drops the excess
      if (cf_hit) begin
         st_nxt.cf_timer = meter_pkg::CF_PULSE_CYC;
         st_nxt.slow_div = slow_hit ? 8'h00 : st_r.slow_div + 8'h01;
      end else if (st_r.cf_timer != 8'h00) begin
         st_nxt.cf_timer = st_r.cf_timer - 8'h01;
      end
      // slow quanta alternate between the two outputs for stepper drive
      if (slow_hit) begin
         st_nxt.slow_timer  = 32'(SLOW_PULSE_CYC);
         st_nxt.slow_on_b   = !st_r.slow_on_b;
         st_nxt.pulse_count = st_r.pulse_count + 32'h00000001;
      end else if (st_r.slow_timer != 32'h00000000) begin
         st_nxt.slow_timer = st_r.slow_timer - 32'h00000001;
      end
      if (!supply_ok) begin
         st_nxt.cf_acc     = '0;
         st_nxt.slow_div   = 8'h00;
         st_nxt.cf_timer   = 8'h00;
         st_nxt.slow_timer = 32'h00000000;
         st_nxt.rev        = 1'b0;
      end
      st_nxt.cf_out  = st_nxt.cf_timer != 8'h00;
      st_nxt.pulse_a = st_nxt.slow_timer != 32'h00000000 && !st_nxt.slow_on_b;
      st_nxt.pulse_b = st_nxt.slow_timer != 32'h00000000 && st_nxt.slow_on_b;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_r           <= '0;
         st_r.ctrl      <= meter_pkg::CTRL_RESET;
         st_r.slow_on_b <= 1'b1;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign awready               = st_r.awready;
   assign wready                = st_r.wready;
   assign bvalid                = st_r.bvalid;
   assign bresp                 = st_r.bresp;
   assign arready               = st_r.arready;
   assign rvalid                = st_r.rvalid;
   assign rresp                 = st_r.rresp;
   assign rdata                 = st_r.rdata;
   assign calibration_pulse_out = st_r.cf_out;
   assign energy_pulse_a        = st_r.pulse_a;
   assign energy_pulse_b        = st_r.pulse_b;
   assign reverse_power_flag    = st_r.rev;

   // ============================================================
   // checks
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence s_slow_quantum;
      cf_hit && st_r.slow_div == meter_pkg::CF_TO_SLOW - 8'h01;
   endsequence

   a_outputs_gated: assert property (!supply_ok |=> !calibration_pulse_out
      && !energy_pulse_a && !energy_pulse_b && !reverse_power_flag)
      else $error("output active while supply not good");
   a_cf_from_cross: assert property (cf_hit |=> calibration_pulse_out)
      else $error("threshold crossing gave no calibration pulse");
   a_cf_width: assert property ($rose(calibration_pulse_out)
      |-> st_r.cf_timer == meter_pkg::CF_PULSE_CYC)
      else $error("calibration pulse started with wrong width");
   a_slow_from_cf: assert property (cf_hit && !slow_hit
      |=> st_r.slow_div == $past(st_r.slow_div) + 8'h01)
      else $error("calibration quantum not counted toward a slow quantum");
   a_slow_restart: assert property (s_slow_quantum |=> st_r.slow_div == 8'h00
      && st_r.slow_timer == 32'(SLOW_PULSE_CYC))
      else $error("slow quantum did not restart divider and pulse timer");
   a_slow_pulse_out: assert property (s_slow_quantum ##1 supply_ok
      |-> energy_pulse_a ^ energy_pulse_b)
      else $error("slow quantum gave no single active-high pulse");
   a_abs_positive: assert property (st_r.valid_d && !sum_mode_select_n
      |-> addend >= meter_pkg::magnitude(total_signed))
      else $error("magnitude mode let a phase subtract");
   a_arith_signed: assert property (st_r.valid_d && sum_mode_select_n
      |-> addend == meter_pkg::magnitude(ext[0] + ext[1] + ext[2]))
      else $error("arithmetic mode did not use the signed sum");
   a_abs_reverse: assert property (supply_ok && st_r.valid_d
      && !sum_mode_select_n && |neg_now |=> reverse_power_flag)
      else $error("negative phase missed in magnitude mode");
   a_rev_signed: assert property (supply_ok && st_r.valid_d && sum_mode_select_n
      && total_signed < 0 |=> reverse_power_flag)
      else $error("signed mode missed a negative total");
   a_residue_bounded: assert property (cf_hit |=> st_r.cf_acc < $past(thr))
      else $error("accumulator residue not below one threshold");
   a_pulse_counted: assert property (slow_hit |=> st_r.pulse_count
      == $past(st_r.pulse_count) + 32'h00000001)
      else $error("slow quantum not counted");
   a_acc_cleared: assert property (!supply_ok |=> st_r.cf_acc == '0
      && st_r.slow_div == 8'h00)
      else $error("accumulator kept energy while supply not good");
endmodule

// >>> verilog/supply_monitor.sv
// ============================================================
// filtered supply-good flag with counting hysteresis
// assumes supply_above_trigger comes from an analog comparator
`timescale 1ns/1ps
module supply_monitor (
   input  wire logic aclk,
   input  wire logic aresetn,
   input  wire logic supply_above_trigger,
   output logic      supply_ok
);
   typedef struct packed {
      logic [10:0] cnt;
      logic        ok;
   } supply_state_t;

   supply_state_t st_r;
   supply_state_t st_nxt;

   // ============================================================
   // integrate up and down; flip only at the ends of the range
   always_comb begin
      st_nxt = st_r;
      if (supply_above_trigger && st_r.cnt != meter_pkg::SUPPLY_FILT_CYC) begin
         st_nxt.cnt = st_r.cnt + 11'h001;
      end else if (!supply_above_trigger && st_r.cnt != 11'h000) begin
         st_nxt.cnt = st_r.cnt - 11'h001;
      end
      if (st_nxt.cnt == meter_pkg::SUPPLY_FILT_CYC) begin
         st_nxt.ok = 1'b1;
      end else if (st_nxt.cnt == 11'h000) begin
         st_nxt.ok = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign supply_ok = st_r.ok;

   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_rise_filtered: assert property ($rose(supply_ok) |->
      $past(supply_above_trigger) && st_r.cnt == meter_pkg::SUPPLY_FILT_CYC)
      else $error("supply good rose before the filter filled");
   a_dip_ignored: assert property (supply_ok && !supply_above_trigger
      && st_r.cnt > 11'h001 |=> supply_ok)
      else $error("short supply dip dropped supply good");
endmodule
